// ### tml_pkg.sv
// tape micro loader: shared constants, opcodes, register map, types
// assumes a 16-bit micro word and a 32-bit classic wishbone data bus
package tml_pkg;

	// tape frame geometry
	localparam int WORD_BITS = 16;       // one micro or data word
	localparam int CHAR_BITS = 8;        // half word per character
	localparam int BYTE_BITS = 10;       // lead + 8 data + parity
	localparam int LIT_BITS  = 24;       // literal width
	localparam logic [3:0] BIT_LAST = 4'h9;  // last bit index of a byte
	localparam logic [1:0] BYTE_HI0 = 2'h0;  // high char, first copy
	localparam logic [1:0] BYTE_HI1 = 2'h1;  // high char, duplicate
	localparam logic [1:0] BYTE_LO0 = 2'h2;  // low char, first copy
	localparam logic [1:0] BYTE_LO1 = 2'h3;  // low char, duplicate

	// fixed micro encodings
	localparam logic [15:0] OP_TAPE_START = 16'h0020;
	localparam logic [15:0] OP_TAPE_STOP  = 16'h0022;
	localparam logic [15:0] OP_TAPE_TO_X  = 16'h1be0;

	// micro groups (top nibble) and field positions
	localparam int GRP_HI = 15;
	localparam int GRP_LO = 12;
	localparam logic [3:0] GRP_REG_MOVE  = 4'h1;
	localparam logic [3:0] GRP_MEM_WRITE = 4'h7;
	localparam logic [3:0] GRP_LIT_MOVE  = 4'h9;
	localparam int SRC_HI = 11;
	localparam int SRC_LO = 8;
	localparam int SNK_HI = 7;
	localparam int SNK_LO = 4;
	localparam int MW_SRC_Y = 6;         // memory write source: 1 = Y
	localparam int LIT_UP_HI = 7;        // upper literal bits in micro

	// register selector codes in move micros
	localparam logic [3:0] SEL_TAPE = 4'hb;
	localparam logic [3:0] SEL_X    = 4'he;
	localparam logic [3:0] SEL_EXEC = 4'hf;
	localparam logic [3:0] SEL_TOP  = 4'hc;
	localparam logic [3:0] SEL_A    = 4'h4;

	// wishbone register byte addresses
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_STAT  = 8'h04;
	localparam logic [7:0] ADR_EXEC  = 8'h08;
	localparam logic [7:0] ADR_TWORD = 8'h0c;
	localparam logic [7:0] ADR_X     = 8'h10;
	localparam logic [7:0] ADR_Y     = 8'h14;
	localparam logic [7:0] ADR_MAR   = 8'h18;
	localparam logic [7:0] ADR_FA    = 8'h1c;
	localparam logic [7:0] ADR_MEM   = 8'h20;

	// control and status bit positions
	localparam int CTRL_TAPE_EXEC = 0;
	localparam int CTRL_RUN       = 1;
	localparam int CTRL_START     = 2;
	localparam int ST_FULL   = 0;
	localparam int ST_DRIVE  = 1;
	localparam int ST_STALL  = 2;
	localparam int ST_BUSY   = 3;
	localparam int ST_LIT    = 4;
	localparam int ST_PERR   = 5;
	localparam int ST_BYTE   = 8;

	// run-mode sequencer
	typedef enum logic [1:0] {RS_IDLE, RS_FETCH, RS_LOAD, RS_EXEC} tml_run_t;

endpackage

// ### tml_sync.sv
// tape micro loader: plain two-flop synchroniser, W bits wide
// assumes d changes asynchronously; also serves as reset release
`timescale 1ns/1ps
module tml_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// level in and synchronised level out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;  // metastable stage, read only by s2
		logic [W-1:0] s2;  // settled stage
	} tml_sync_t;

	tml_sync_t r_r;
	tml_sync_t r_nxt;

	// shift one stage per edge
	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = d;
		r_nxt.s2 = r_r.s1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign q = r_r.s2;

endmodule

// ### tml_deframer.sv
// tape micro loader: serial tape bits to 16-bit words
// assumes tapeClk and tapeData already synchronised to clk_sys
`timescale 1ns/1ps
module tml_deframer
	import tml_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstSync_n,
	// assembly enable, low clears all progress
	input  wire logic        enable,
	// synchronised tape lines
	input  wire logic        tapeClk,
	input  wire logic        tapeData,
	// assembled word
	output logic             wordStrobe,
	output logic [15:0]      word,
	output logic             parityFail,
	output logic [1:0]       byteCount
);

	typedef struct packed {
		logic        clkPrev;  // tape clock last cycle
		logic        seen;     // data seen in this clock window
		logic [9:0]  sh;       // lower assembly register
		logic [3:0]  bitCnt;   // bit within byte
		logic [1:0]  byteCnt;  // byte within word
		logic        hiOk;     // high half accepted
		logic        loOk;     // low half accepted
		logic [7:0]  hi;
		logic [7:0]  lo;
		logic        strobe;
		logic [15:0] word;
		logic        fail;
	} tml_dfr_t;

	tml_dfr_t r_r;
	tml_dfr_t r_nxt;

	// bit capture, byte check, duplicate handling
	always_comb begin
		logic [9:0] frame;
		logic       good;
		logic       loGood;
		frame  = '0;
		good   = 1'b0;
		loGood = 1'b0;
		r_nxt  = r_r;
		r_nxt.strobe  = 1'b0;
		r_nxt.fail    = 1'b0;
		r_nxt.clkPrev = tapeClk;
		if (!enable) begin
			// first byte after a start is byte 0
			r_nxt.seen    = 1'b0;  // see RL22
			r_nxt.bitCnt  = '0;
			r_nxt.byteCnt = BYTE_HI0;
			r_nxt.hiOk    = 1'b0;
			r_nxt.loOk    = 1'b0;
		end else begin
			// one data bit per clock window, extra pulses are noise
			if (tapeClk && tapeData) begin
				r_nxt.seen = 1'b1;  // see RL9
			end
			// bit cell ends at the falling tape clock
			if (r_r.clkPrev && !tapeClk) begin
				frame      = {r_r.sh[8:0], r_r.seen};  // see RL6
				r_nxt.sh   = frame;
				r_nxt.seen = 1'b0;
				if (r_r.bitCnt == BIT_LAST) begin
					r_nxt.bitCnt  = '0;
					r_nxt.byteCnt = r_r.byteCnt + 2'h1;  // see RL6
					// lead one, then even parity over all ten
					good = frame[9] && !(^frame);  // see RL3 see RL4
					unique case (r_r.byteCnt)
						BYTE_HI0: begin
							r_nxt.hiOk = good;
							r_nxt.hi   = frame[8:1];  // see RL7
						end
						BYTE_HI1: begin
							// retry only if the first copy failed
							if (!r_r.hiOk && good) begin  // see RL5 see RL23
								r_nxt.hiOk = 1'b1;
								r_nxt.hi   = frame[8:1];
							end
						end
						BYTE_LO0: begin
							r_nxt.loOk = good;
							r_nxt.lo   = frame[8:1];
						end
						BYTE_LO1: begin
							loGood = r_r.loOk || good;  // see RL5
							// high char first, four chars a word
							if (r_r.hiOk && loGood) begin  // see RL1 see RL2
								r_nxt.strobe = 1'b1;
								r_nxt.word   = {r_r.hi,
									(r_r.loOk ? r_r.lo : frame[8:1])};  // see RL23
							end else begin
								r_nxt.fail = 1'b1;
							end
							r_nxt.hiOk = 1'b0;
							r_nxt.loOk = 1'b0;
						end
					endcase
				end else begin
					r_nxt.bitCnt = r_r.bitCnt + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign wordStrobe = r_r.strobe;
	assign word       = r_r.word;
	assign parityFail = r_r.fail;
	assign byteCount  = r_r.byteCnt;

endmodule

// ### tml_loader.sv
// tape micro loader: top, wishbone slave, micro sequencer, word router
// assumes a classic wishbone master on clk_sys and async tape pins
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Function
// RL1: each word is forty tape bits
// RL2: high char first, each char recorded twice
// RL3: byte is lead one, eight data, parity
// RL4: parity makes the ten bits even
// RL5: duplicate copy retries a failed half
// RL6: ten-bit assembly with byte counter 0-3
// RL7: only sixteen data bits reach sinks
// RL8: literal move spans two tape words
// RL9: cassette clocks every bit position
// RL10: tape mode executes each tape word
// RL11: word after literal move feeds literal
// RL12: run mode fetches, latches, executes micros
// RL13: move to execute register ORs next micro; the code ORs only X, at the next run-mode load, never into tape-mode micros
// RL14: start tape micro applies forward drive
// RL15: 0020 starts tape, 0022 stops it
// RL16: tape move stalls until word full
// RL17: stack top, A, execute never tape sinks
// RL18: memory write stores, advances field address
// RL19: run starts at memory address register
// RL20: 1BE0 moves tape word to X
// RL21: tape word gate lasts one cycle
// RL22: first byte after start is byte 0
// RL23: good first copy discards the duplicate
module tml_loader
	import tml_pkg::*;
#(
	parameter int MEM_AW = 4  // main memory address bits
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [3:0]  wbSel,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [31:0] wbDatI,
	output logic      [31:0] wbDatO,
	output logic             wbAck,
	// cassette pins
	input  wire logic        tapeClkPin,
	input  wire logic        tapeDataPin,
	output logic             tapeDriveFwd,
	// tape word gate strobe
	output logic             tapeWordGate
);

	localparam int MEM_DEPTH = 1 << MEM_AW;

	// memory index must fit the address registers and stay small
	generate
		if (MEM_AW < 2 || MEM_AW > 8) begin : gBadAw
			$error("tml_loader: MEM_AW out of range");
		end
	endgenerate

	typedef struct packed {
		logic                             ack;      // bus answer
		logic [31:0]                      dat;      // bus read data
		logic                             tapeExec; // tape_execute_mode
		logic                             runMode;  // fetch from memory
		tml_run_t                         state;    // run sequencer
		logic [MEM_AW-1:0]                pc;       // fetch address
		logic [MEM_AW-1:0]                mar;      // memory_address_register
		logic [MEM_AW-1:0]                fa;       // field_address
		logic [15:0]                      latch;    // micro_latch
		logic [15:0]                      exec;     // micro execute register
		logic                             execFire; // exec holds a new micro
		logic [15:0]                      orPend;   // OR into next micro
		logic [15:0]                      x;        // X sink
		logic [23:0]                      y;        // literal sink
		logic [15:0]                      tapeWord; // tape assembly register
		logic                             tapeFull; // tape word waiting
		logic                             drive;    // forward drive
		logic                             litPend;  // next tape word is literal
		logic                             pendX;    // tape to X waiting
		logic                             perr;     // sticky parity failure
		logic                             gate;     // tape_word_gate
		logic [MEM_DEPTH-1:0][15:0]       mem;      // main memory
	} tml_top_t;

	tml_top_t r_r;
	tml_top_t r_nxt;

	logic        rstSync_n;  // released reset
	logic [1:0]  tapeSync;   // {clock, data} after two flops
	logic        dfStrobe;   // word assembled
	logic [15:0] dfWord;
	logic        dfFail;     // both copies of a half failed
	logic [1:0]  dfByte;     // byte in progress

	// reset release: asserts at once, releases after two edges
	tml_sync #(
		.W (1)
	) uRstSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (1'b1),
		.q       (rstSync_n)
	);

	// tape pins come from another world, two flops before use
	tml_sync #(
		.W (2)
	) uPinSync (
		.clk_sys (clk_sys),
		.rst_n   (rstSync_n),
		.d       ({tapeClkPin, tapeDataPin}),
		.q       (tapeSync)
	);

	// assembly only runs while the tape is driven
	tml_deframer uDeframer (
		.clk_sys    (clk_sys),
		.rstSync_n  (rstSync_n),
		.enable     (r_r.drive),
		.tapeClk    (tapeSync[1]),
		.tapeData   (tapeSync[0]),
		.wordStrobe (dfStrobe),
		.word       (dfWord),
		.parityFail (dfFail),
		.byteCount  (dfByte)
	);

	// byte lane mask from wishbone selects
	function automatic logic [31:0] laneMask(input logic [3:0] sel);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{sel[i]}};
		end
		return m;
	endfunction

	// whole next state: bus, sequencer, router, decoder
	always_comb begin
		logic [31:0] rd;
		logic [31:0] wv;
		logic        hit;
		logic [3:0]  src;
		logic [3:0]  snk;
		r_nxt = r_r;
		r_nxt.ack      = 1'b0;
		r_nxt.gate     = 1'b0;
		r_nxt.execFire = 1'b0;
		hit = wbCyc && wbStb && !r_r.ack;
		src = r_r.exec[SRC_HI:SRC_LO];
		snk = r_r.exec[SNK_HI:SNK_LO];

		// read view of every register
		rd = '0;
		unique case (wbAdr)
			ADR_CTRL: begin
				rd[CTRL_TAPE_EXEC] = r_r.tapeExec;
				rd[CTRL_RUN]       = r_r.runMode;
			end
			ADR_STAT: begin
				rd[ST_FULL]  = r_r.tapeFull;
				rd[ST_DRIVE] = r_r.drive;
				rd[ST_STALL] = r_r.pendX;
				rd[ST_BUSY]  = (r_r.state != RS_IDLE);
				rd[ST_LIT]   = r_r.litPend;
				rd[ST_PERR]  = r_r.perr;
				rd[ST_BYTE +: 2] = dfByte;
			end
			ADR_EXEC:  rd[15:0] = r_r.exec;
			ADR_TWORD: rd[15:0] = r_r.tapeWord;
			ADR_X:     rd[15:0] = r_r.x;
			ADR_Y:     rd[23:0] = r_r.y;
			ADR_MAR:   rd[MEM_AW-1:0] = r_r.mar;
			ADR_FA:    rd[MEM_AW-1:0] = r_r.fa;
			ADR_MEM:   rd[15:0] = r_r.mem[r_r.fa];
			default:   rd = '0;  // unmapped reads zero
		endcase
		wv = (rd & ~laneMask(wbSel)) | (wbDatI & laneMask(wbSel));

		// one-cycle answer; read data is the value before any write
		if (hit) begin
			r_nxt.ack = 1'b1;
			r_nxt.dat = rd;
		end
		// write lands at the edge where the master samples ack high,
		// while it still holds address, selects and data
		if (wbCyc && wbStb && r_r.ack) begin
			if (wbWe) begin
				unique case (wbAdr)
					ADR_CTRL: begin
						r_nxt.tapeExec = wv[CTRL_TAPE_EXEC];
						r_nxt.runMode  = wv[CTRL_RUN];
						// start runs from the address register
						if (wv[CTRL_START] && wv[CTRL_RUN]) begin
							r_nxt.pc    = r_r.mar;  // see RL19
							r_nxt.state = RS_FETCH;
						end
					end
					ADR_STAT: begin
						// write one clears; a new failure below wins
						if (wv[ST_PERR]) begin
							r_nxt.perr = 1'b0;
						end
					end
					ADR_X:   r_nxt.x   = wv[15:0];
					ADR_MAR: r_nxt.mar = wv[MEM_AW-1:0];
					ADR_FA:  r_nxt.fa  = wv[MEM_AW-1:0];
					ADR_MEM: r_nxt.mem[r_r.fa] = wv[15:0];
					default: ;  // read-only or unmapped: ignored
				endcase
			end
		end

		// run sequencer: fetch, latch, execute
		unique case (r_r.state)
			RS_IDLE: ;
			RS_FETCH: begin
				r_nxt.latch = r_r.mem[r_r.pc];  // see RL12
				r_nxt.pc    = r_r.pc + 1'b1;
				r_nxt.state = RS_LOAD;
			end
			RS_LOAD: begin
				// pending move into the execute register alters it
				r_nxt.exec     = r_r.latch | r_r.orPend;  // see RL13
				r_nxt.orPend   = '0;
				r_nxt.execFire = 1'b1;  // see RL12
				r_nxt.state    = RS_EXEC;
			end
			RS_EXEC: begin
				// tape move holds the micro until a word arrives
				if (!r_r.execFire && !r_r.pendX) begin  // see RL16
					r_nxt.state = RS_FETCH;
				end
			end
		endcase
		if (!r_nxt.runMode) begin
			r_nxt.state = RS_IDLE;
		end

		// pending tape-to-X takes the word first
		if (r_r.pendX && r_r.tapeFull) begin
			r_nxt.x        = r_r.tapeWord;  // see RL16
			r_nxt.tapeFull = 1'b0;
			r_nxt.pendX    = 1'b0;
		end else if (r_r.tapeExec && r_r.state == RS_IDLE &&
			r_r.tapeFull && !r_r.gate && !r_r.execFire) begin
			// clearing full keeps the gate to a single cycle
			r_nxt.gate     = 1'b1;  // see RL21
			r_nxt.tapeFull = 1'b0;
			if (r_r.litPend) begin
				// literal tail is routed, never executed
				r_nxt.y = {r_r.exec[LIT_UP_HI:0], r_r.tapeWord};  // see RL11
				r_nxt.litPend = 1'b0;
			end else begin
				r_nxt.exec     = r_r.tapeWord;  // see RL10
				r_nxt.execFire = 1'b1;
			end
		end

		// decode the micro just placed in the execute register
		if (r_r.execFire) begin
			if (r_r.exec == OP_TAPE_START) begin
				r_nxt.drive = 1'b1;  // see RL14 see RL15
			end else if (r_r.exec == OP_TAPE_STOP) begin
				// no gap sense here, drive simply drops
				r_nxt.drive = 1'b0;  // see RL15
			end else if (r_r.exec == OP_TAPE_TO_X) begin
				r_nxt.pendX = 1'b1;  // see RL20
			end else if (r_r.exec[GRP_HI:GRP_LO] == GRP_LIT_MOVE) begin
				if (r_r.state == RS_IDLE) begin
					// lower sixteen literal bits are the next tape word
					r_nxt.litPend = 1'b1;  // see RL8 see RL11
				end else begin
					// run mode takes them from the next memory word
					r_nxt.y  = {r_r.exec[LIT_UP_HI:0], r_r.mem[r_r.pc]};
					r_nxt.pc = r_r.pc + 1'b1;
				end
			end else if (r_r.exec[GRP_HI:GRP_LO] == GRP_MEM_WRITE) begin
				r_nxt.mem[r_r.fa] = r_r.exec[MW_SRC_Y] ? r_r.y[15:0]
					: r_r.x;  // see RL18
				r_nxt.fa = r_r.fa + 1'b1;  // see RL18
			end else if (r_r.exec[GRP_HI:GRP_LO] == GRP_REG_MOVE) begin
				if (src == SEL_TAPE) begin
					// stack top, A and execute refused as tape sinks
					if (snk == SEL_X) begin  // see RL17
						r_nxt.pendX = 1'b1;  // see RL16
					end
				end else if (src == SEL_X && snk == SEL_EXEC) begin
					r_nxt.orPend = r_r.x;  // see RL13
				end
			end
		end

		// arrival last so a new word beats a same-cycle consume
		if (dfStrobe) begin
			r_nxt.tapeWord = dfWord;  // see RL7
			r_nxt.tapeFull = 1'b1;
		end
		if (dfFail) begin
			r_nxt.perr = 1'b1;
		end
		// stopping the tape drops any half-done literal wait
		if (!r_nxt.drive) begin
			r_nxt.litPend = r_nxt.litPend && r_nxt.tapeFull;
		end
	end

	// single state register
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// outputs straight from flops
	assign wbAck        = r_r.ack;
	assign wbDatO       = r_r.dat;
	assign tapeDriveFwd = r_r.drive;
	assign tapeWordGate = r_r.gate;

endmodule

// ### tml_loader_sva.sv
// tape micro loader: port-level assertions, bound to the top module
// assumes a classic wishbone master and a tape clock far below clk_sys
`timescale 1ns/1ps
module tml_loader_sva #(
	parameter int MEM_AW = 4  // kept in step with the design
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// wishbone
	input wire logic        wbCyc,
	input wire logic        wbStb,
	input wire logic        wbWe,
	input wire logic [3:0]  wbSel,
	input wire logic [7:0]  wbAdr,
	input wire logic [31:0] wbDatI,
	input wire logic [31:0] wbDatO,
	input wire logic        wbAck,
	// cassette side
	input wire logic        tapeClkPin,
	input wire logic        tapeDataPin,
	input wire logic        tapeDriveFwd,
	input wire logic        tapeWordGate
);
	localparam int CELLS_PER_WORD = 40;
	typedef struct packed {
		logic        clkSeen;  // last sampled tape clock
		logic [15:0] cells;    // cell ends since last gate, saturating
	} tml_chk_t;
	tml_chk_t s_r;    // helper state
	tml_chk_t s_nxt;  // its next value
	// count tape clock falls; leads the design by its synchroniser only
	always_comb begin
		s_nxt = s_r;
		s_nxt.clkSeen = tapeClkPin;
		if (tapeWordGate) begin
			s_nxt.cells = 16'h0;
		end else if (s_r.clkSeen && !tapeClkPin && s_r.cells != 16'hffff) begin
			s_nxt.cells = s_r.cells + 16'h1;
		end
	end
	// helper register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	a_ack_one_pulse: assert property (wbAck |=> !wbAck)
		else $error("ack held longer than one cycle");
	a_ack_next_cycle: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("request not answered in the next cycle");
	a_ack_has_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
		else $error("ack without a request");
	a_idle_no_ack: assert property (
		!(wbCyc && wbStb) ##1 !(wbCyc && wbStb) |-> !wbAck)
		else $error("ack on an idle bus");
	a_gate_one_cycle: assert property (
		$rose(tapeWordGate) |=> $fell(tapeWordGate))
		else $error("tape word gate wider than one cycle");
	a_gate_needs_drive: assert property (
		tapeWordGate |-> $past(tapeDriveFwd, 2))
		else $error("tape word gate with tape not driven");
	a_gate_whole_word: assert property (
		tapeWordGate |-> s_r.cells >= CELLS_PER_WORD)
		else $error("tape word gate before forty bit cells");
	a_reset_quiet: assert property ($rose(rst_n) |->
		(!tapeDriveFwd && !tapeWordGate && !wbAck) [*3])
		else $error("output active just after reset");
endmodule

bind tml_loader tml_loader_sva #(.MEM_AW(MEM_AW)) tml_loader_sva_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
	.wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI),
	.wbDatO(wbDatO), .wbAck(wbAck), .tapeClkPin(tapeClkPin),
	.tapeDataPin(tapeDataPin), .tapeDriveFwd(tapeDriveFwd),
	.tapeWordGate(tapeWordGate));

// ### tml_cassette_model.sv
// tape micro loader: behavioural read-only cassette with clock track
// assumes the bench calls send_word; each word starts only under drive, then plays out whole
`timescale 1ns/1ps
module tml_cassette_model (
	// drive from the loader
	input  wire logic tapeDriveFwd,
	// serial lines to the loader
	output logic      tapeClkPin,
	output logic      tapeDataPin
);
	localparam int HALF_NS = 40;  // 80 ns cell, clock high half of it
	localparam int SKEW_NS = 3;   // keeps pin edges off clk_sys edges
	// clock track stands still between frames
	initial begin
		tapeClkPin  = 1'b0;
		tapeDataPin = 1'b0;
	end
	// one cell: clock always present, short data pulse mid-way through the clock high half
	task automatic send_bit(input logic b);
		tapeClkPin = 1'b1;
		#(HALF_NS / 4) tapeDataPin = b;
		#(HALF_NS / 2) tapeDataPin = 1'b0;
		#(HALF_NS / 4) tapeClkPin = 1'b0;
		#(HALF_NS);
	endtask
	// lead one, data msb first, even parity; spoil flips the parity
	task automatic send_char(input logic [7:0] c, input logic spoil);
		logic par;
		par = ^{1'b1, c} ^ spoil;
		send_bit(1'b1);
		for (int i = 7; i >= 0; i--) begin
			send_bit(c[i]);
		end
		send_bit(par);
	endtask
	// high half first, each half twice; spoil bit n hits character n
	task automatic send_word(input logic [15:0] w, input logic [3:0] spoil);
		wait (tapeDriveFwd === 1'b1);  // no motion without drive
		#(SKEW_NS);
		send_char(w[15:8], spoil[0]);
		send_char(w[15:8], spoil[1]);
		send_char(w[7:0], spoil[2]);
		send_char(w[7:0], spoil[3]);
	endtask
endmodule

// ### tml_loader_tb_top.sv
// tape micro loader: self-checking bench over wishbone and tape model
// assumes a 100 MHz clk_sys and the cassette model beside the loader
`timescale 1ns/1ps
module tml_loader_tb_top
	import tml_pkg::*;
;
	logic        clk_sys = 1'b0;  // system clock
	logic        rst_n = 1'b0;    // async reset, active low
	logic        wbCyc, wbStb, wbWe;
	logic [3:0]  wbSel;
	logic [7:0]  wbAdr;
	logic [31:0] wbDatI, wbDatO;
	logic        wbAck, tapeClkPin, tapeDataPin, tapeDriveFwd, tapeWordGate;
	int          err_count = 0;  // mismatches
	int          checks = 0;     // comparisons made
	int          gateCount = 0;  // tape word gate pulses seen
	int          gateBase;       // gate count at start of tape mode
	logic [15:0] prog [13] = '{16'h7950, 16'h1ef0, 16'h0000, 16'h1be0,
		16'h7910, 16'h1be0, 16'h7910, 16'h0022,  // word 0 is a trap
		16'h9155, 16'h1234, 16'h7950, 16'h1bc0, 16'h0020};  // run at 20
	tml_loader #(.MEM_AW(5)) tml_loader_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
		.wbAck(wbAck), .tapeClkPin(tapeClkPin), .tapeDataPin(tapeDataPin),
		.tapeDriveFwd(tapeDriveFwd), .tapeWordGate(tapeWordGate));
	tml_cassette_model tml_cassette_model_inst (.tapeDriveFwd(tapeDriveFwd),
		.tapeClkPin(tapeClkPin), .tapeDataPin(tapeDataPin));
	always #5 clk_sys = ~clk_sys;
	// count gate pulses
	always @(posedge clk_sys) begin
		if (tapeWordGate === 1'b1) begin
			gateCount <= gateCount + 1;
		end
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] adr,
		input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= adr;
		wbDatI <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			check("bus answer", 32'h0, 32'h1);
		end
		rdat = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb_xfer(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] x;
		wb_xfer(1'b0, a, 32'h0, x);
		check(what, x, exp);
	endtask
	// poll a status bit, bounded
	task automatic wait_stat(input int bitn, input logic v);
		logic [31:0] x;
		int n;
		n = 0;
		do begin
			wb_xfer(1'b0, ADR_STAT, 32'h0, x);
			n++;
		end while (x[bitn] !== v && n < 3000);
		if (x[bitn] !== v) begin
			check("status wait", 32'h0, 32'h1);
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#300000;
		check("watchdog", 32'h1, 32'h0);
		tally_and_finish();
	end
	// main sequence
	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
		wbSel = 4'hf;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("drive idle", {31'h0, tapeDriveFwd}, 32'h0);
		rd_chk("status reset", ADR_STAT, 32'h0);
		rd_chk("unmapped", 8'h3c, 32'h0);
		wr(ADR_EXEC, 32'h1234);
		rd_chk("exec read only", ADR_EXEC, 32'h0);
		wr(ADR_X, 32'h1234);
		wbSel <= 4'h1;  // low lane only
		wr(ADR_X, 32'hffff_ffab);
		wbSel <= 4'hf;
		rd_chk("lane merge", ADR_X, 32'h12ab);
		// run: X or-ed into a no-op makes start tape, then two tape words
		for (int i = 0; i < 8; i++) begin
			wr(ADR_FA, i);
			wr(ADR_MEM, {16'h0, prog[i]});
		end
		wr(ADR_FA, 32'd16);
		wr(ADR_X, 32'h0020);
		wr(ADR_MAR, 32'h1);
		wr(ADR_CTRL, 32'h6);
		wait_stat(ST_STALL, 1'b1);
		rd_chk("stalled status", ADR_STAT, 32'he);
		tml_cassette_model_inst.send_word(16'h5ac3, 4'h1);
		tml_cassette_model_inst.send_word(16'h3c81, 4'h2);
		wait_stat(ST_DRIVE, 1'b0);
		wr(ADR_CTRL, 32'h0);
		rd_chk("field address", ADR_FA, 32'd18);
		rd_chk("x from tape", ADR_X, 32'h3c81);
		wr(ADR_FA, 32'd16);
		rd_chk("stored first", ADR_MEM, 32'h5ac3);
		wr(ADR_FA, 32'd17);
		rd_chk("stored second", ADR_MEM, 32'h3c81);
		// run: memory literal, write from Y, refused sink, start tape
		for (int i = 8; i < 13; i++) begin
			wr(ADR_FA, i + 12);
			wr(ADR_MEM, {16'h0, prog[i]});
		end
		wr(ADR_FA, 32'd25);
		wr(ADR_MAR, 32'd20);
		wr(ADR_CTRL, 32'h6);
		wait_stat(ST_DRIVE, 1'b1);
		wr(ADR_CTRL, 32'h1);
		rd_chk("run literal", ADR_Y, 32'h00551234);
		rd_chk("fa after write", ADR_FA, 32'd26);
		wr(ADR_FA, 32'd25);
		rd_chk("stored literal", ADR_MEM, 32'h1234);
		gateBase = gateCount;
		tml_cassette_model_inst.send_word(16'h9123, 4'h0);
		tml_cassette_model_inst.send_word(16'habcd, 4'h0);
		repeat (8) @(posedge clk_sys);  // full then consume, a few cycles
		rd_chk("literal", ADR_Y, 32'h0023abcd);
		rd_chk("exec kept", ADR_EXEC, 32'h9123);
		tml_cassette_model_inst.send_word(16'h4444, 4'h3);  // both copies bad
		repeat (8) @(posedge clk_sys);
		rd_chk("parity fail", ADR_STAT, 32'h22);
		wr(ADR_STAT, 32'h20);
		tml_cassette_model_inst.send_word(16'h0022, 4'h0);
		repeat (8) @(posedge clk_sys);
		rd_chk("stopped", ADR_STAT, 32'h0);
		rd_chk("exec stop", ADR_EXEC, 32'h0022);
		check("gate pulses", gateCount - gateBase, 32'd3);
		tally_and_finish();
	end
endmodule
